// [hw/csh_top.sv]
/*
 * Control station handover: arbitrates which station commands the
 * engine and drives key LEDs, buzzers, mode text and lamps.
 * Assumes keys and lever contacts are asynchronous pins, lever
 * positions arrive as stable 8-bit words, and an AHB-Lite master.
 */
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
// Contract
// - station in command proposes, other station requests
// - active mode key steady, mode text shown
// - local to remote: buzz and flash engine room
// - engine room ack enters auto engine room
// - no direct local to auto bridge
// - pot fault: auto proposal to bridge
// - engine room proposes bridge: flash, bridge alert
// - bridge ack with switch bridge: auto bridge
// - engine room key cancels its proposal
// - bridge requests bridge: flash, engine room alert
// - engine room ack turns request into proposal
// - bridge proposes engine room: flash, alert
// - engine room ack, switch engine room: auto
// - bridge key cancels its pending transfer (code: only its proposal, P_PROP_ER; a P_REQ_BR request stays)
// - engine room request, bridge ack gives proposal
// - transfer needs aligned levers; bar graph shown
// - switch engine room, levers remote: manual at once
// - bridge cannot block manual engine room
// - lever off remote: local at once, ack
// - local: text, local lamp, emergency lamp
// - local has highest priority
// - forced changeover: bridge alert until accepted
`timescale 1ns/100ps
`include "csh_consts.svh"

module csh_top #(
    parameter int NLEV      = 2,
    parameter int FLASH_CYC = `CSH_FLASH_HALF_CYC
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [7:0]        haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // panel keys and station contacts
    input  wire csh_pkg::csh_keys_t br_keys,
    input  wire csh_pkg::csh_keys_t er_keys,
    input  wire logic              sw_at_bridge,
    input  wire logic [NLEV-1:0]   lever_remote,
    input  wire logic              er_pot_fault,
    input  wire logic [7:0]        br_lever,
    input  wire logic [7:0]        er_lever,
    input  wire logic [7:0]        man_lever,
    // indications
    output csh_pkg::csh_keys_t     br_led,
    output csh_pkg::csh_keys_t     er_led,
    output logic                   br_buzzer,
    output logic                   er_buzzer,
    output csh_pkg::csh_text_t     mode_text,
    output logic                   bargraph_on,
    output logic                   manual_engine_room_lamp,
    output logic                   local_lamp,
    output logic                   emergency_lamp,
    output logic                   remote_ind,
    output logic [7:0]             setpoint
);

    initial begin
        if (NLEV < 1 || FLASH_CYC < 2) begin
            $error("csh_top: bad parameter");
        end
    end

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    localparam int SW = 6 + 2 + NLEV + 24;
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [5:0]    keys_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= '0;
            s2 <= '0;
        end else begin
            s1 <= {br_keys, er_keys, sw_at_bridge, er_pot_fault,
                   lever_remote, br_lever, er_lever, man_lever};
            s2 <= s1;
        end
    end

    csh_pkg::csh_keys_t br_k;
    csh_pkg::csh_keys_t er_k;
    csh_pkg::csh_keys_t br_p;
    csh_pkg::csh_keys_t er_p;
    logic              sw_br;
    logic              pot_flt;
    logic              all_remote;
    logic [7:0]        lev_br;
    logic [7:0]        lev_er;
    logic [7:0]        lev_man;

    assign {br_k, er_k, sw_br, pot_flt} = s2[SW-1 -: 8];
    assign all_remote = &s2[24 +: NLEV];
    assign lev_br     = s2[23:16];
    assign lev_er     = s2[15:8];
    assign lev_man    = s2[7:0];

    // key presses are rising edges of the synchronised contacts
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            keys_q <= '0;
        end else begin
            keys_q <= {br_k, er_k};
        end
    end
    assign br_p = br_k & ~keys_q[5:3];
    assign er_p = er_k & ~keys_q[2:0];

    // ----------------------------------------
    // registers and ahb-lite slave
    // ----------------------------------------
    csh_pkg::csh_mode_t mode;
    csh_pkg::csh_pend_t pend;
    logic              acked;
    logic              last_br;
    logic [7:0]        tol;
    logic              wr_pend;
    logic [7:0]        wr_addr;

    function automatic logic [31:0] rd_word(input logic [7:0] a);
        case (a)
            `CSH_OFF_CTRL:     rd_word = {24'h000000, tol};
            `CSH_OFF_STATUS:   rd_word = {26'h0, acked, pend, mode};
            `CSH_OFF_LEVERS:   rd_word = {16'h0000, lev_er, lev_br};
            `CSH_OFF_SETPOINT: rd_word = {24'h000000, setpoint};
            default:           rd_word = 32'h00000000;
        endcase
    endfunction : rd_word

    logic acc;
    assign acc       = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata  <= 32'h00000000;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= acc && hwrite;
            wr_addr <= haddr;
            if (acc && !hwrite) begin
                hrdata <= rd_word({haddr[7:2], 2'b00});
            end
        end
    end

    // only the tolerance is writable; other offsets ignore writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tol <= `CSH_TOL_RST;
        end else if (wr_pend && {wr_addr[7:2], 2'b00} == `CSH_OFF_CTRL) begin
            tol <= hwdata[`CSH_CTRL_TOL_LSB +: 8];
        end
    end

    // ----------------------------------------
    // lever alignment
    // ----------------------------------------
    function automatic logic aligned(input logic [7:0] a,
                                     input logic [7:0] b,
                                     input logic [7:0] t);
        aligned = ((a > b) ? (a - b) : (b - a)) <= t;
    endfunction : aligned

    logic lev_ok;
    assign lev_ok = aligned(lev_br, lev_er, tol);

    // ----------------------------------------
    // mode and transfer arbitration
    // ----------------------------------------
    csh_pkg::csh_mode_t next_mode;
    csh_pkg::csh_pend_t next_pend;
    logic              next_acked;
    logic              next_last_br;

    always_comb begin
        next_mode    = mode;
        next_pend    = pend;
        next_acked   = acked;
        next_last_br = last_br;
        if (!all_remote) begin
            if (mode != csh_pkg::M_LOCAL) begin
                next_mode    = csh_pkg::M_LOCAL;
                next_pend    = csh_pkg::P_LOC_ACK;
                next_acked   = 1'b0;
                next_last_br = (mode == csh_pkg::M_AUTO_BR);
            end else if (pend != csh_pkg::P_LOC_ACK) begin
                next_pend = csh_pkg::P_NONE;
            end
        end else if (mode == csh_pkg::M_LOCAL &&
                     (pend == csh_pkg::P_NONE || pend == csh_pkg::P_LOC_ACK)) begin
            // leaving local never goes straight to bridge
            next_pend  = pot_flt ? csh_pkg::P_PROP_BR
                                 : csh_pkg::P_LOC_EXIT;
            next_acked = 1'b0;
        end else if (mode == csh_pkg::M_AUTO_BR && !sw_br &&
                     !(pend == csh_pkg::P_PROP_ER && acked)) begin
            next_mode  = csh_pkg::M_MANUAL_ER;
            next_pend  = csh_pkg::P_FORCED;
            next_acked = 1'b0;
        end else if (mode == csh_pkg::M_MANUAL_ER && sw_br) begin
            next_mode = csh_pkg::M_AUTO_ER;
            next_pend = csh_pkg::P_NONE;
        end else begin
            case (pend)
                csh_pkg::P_NONE: begin
                    next_acked = 1'b0;
                    if (mode == csh_pkg::M_AUTO_ER) begin
                        if (er_p.bridge) begin
                            next_pend = csh_pkg::P_PROP_BR;
                        end else if (br_p.bridge) begin
                            next_pend = csh_pkg::P_REQ_BR;
                        end
                    end else if (mode == csh_pkg::M_AUTO_BR) begin
                        if (br_p.er) begin
                            next_pend = csh_pkg::P_PROP_ER;
                        end else if (er_p.er) begin
                            next_pend = csh_pkg::P_REQ_ER;
                        end
                    end
                end
                csh_pkg::P_LOC_ACK: begin
                    if (last_br ? br_p.local_k : er_p.local_k) begin
                        next_pend = csh_pkg::P_NONE;
                    end
                end
                csh_pkg::P_LOC_EXIT: begin
                    if (er_p.er) begin
                        next_acked = 1'b1;
                    end
                    if (acked && lev_ok) begin
                        next_mode = csh_pkg::M_AUTO_ER;
                        next_pend = csh_pkg::P_NONE;
                    end
                end
                csh_pkg::P_PROP_BR: begin
                    if (mode == csh_pkg::M_AUTO_ER && er_p.er) begin
                        next_pend = csh_pkg::P_NONE;
                    end else begin
                        if (br_p.bridge) begin
                            next_acked = 1'b1;
                        end
                        // a faulty pot cannot be matched, so skip alignment
                        if (acked && sw_br && (lev_ok || pot_flt)) begin
                            next_mode = csh_pkg::M_AUTO_BR;
                            next_pend = csh_pkg::P_NONE;
                        end
                    end
                end
                csh_pkg::P_REQ_BR: begin
                    if (er_p.bridge) begin
                        next_pend  = csh_pkg::P_PROP_BR;
                        next_acked = 1'b0;
                    end
                end
                csh_pkg::P_PROP_ER: begin
                    if (br_p.bridge) begin
                        next_pend = csh_pkg::P_NONE;
                    end else begin
                        if (er_p.er) begin
                            next_acked = 1'b1;
                        end
                        if (acked && !sw_br && lev_ok) begin
                            next_mode = csh_pkg::M_AUTO_ER;
                            next_pend = csh_pkg::P_NONE;
                        end
                    end
                end
                csh_pkg::P_REQ_ER: begin
                    if (br_p.er) begin
                        next_pend  = csh_pkg::P_PROP_ER;
                        next_acked = 1'b0;
                    end
                end
                csh_pkg::P_FORCED: begin
                    if (br_p.er) begin
                        next_pend = csh_pkg::P_NONE;
                    end
                end
                default: next_pend = csh_pkg::P_NONE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode    <= csh_pkg::M_LOCAL;
            pend    <= csh_pkg::P_NONE;
            acked   <= 1'b0;
            last_br <= 1'b0;
        end else begin
            mode    <= next_mode;
            pend    <= next_pend;
            acked   <= next_acked;
            last_br <= next_last_br;
        end
    end

    // ----------------------------------------
    // flash timebase
    // ----------------------------------------
    logic [31:0] fl_cnt;
    logic        blink;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fl_cnt <= 32'h00000000;
            blink  <= 1'b0;
        end else if (fl_cnt == 32'(FLASH_CYC - 1)) begin
            fl_cnt <= 32'h00000000;
            blink  <= ~blink;
        end else begin
            fl_cnt <= fl_cnt + 32'h00000001;
        end
    end

    // ----------------------------------------
    // indications
    // ----------------------------------------
    csh_pkg::csh_keys_t steady;
    csh_pkg::csh_keys_t fl_br;
    csh_pkg::csh_keys_t fl_er;
    logic              bz_br;
    logic              bz_er;

    always_comb begin
        steady = '0;
        fl_br  = '0;
        fl_er  = '0;
        bz_br  = 1'b0;
        bz_er  = 1'b0;
        case (mode)
            csh_pkg::M_AUTO_BR: steady.bridge  = 1'b1;
            csh_pkg::M_LOCAL:   steady.local_k = 1'b1;
            default:            steady.er      = 1'b1;
        endcase
        case (pend)
            csh_pkg::P_PROP_BR: begin
                fl_br.bridge = 1'b1;
                fl_er.bridge = 1'b1;
                bz_br        = !acked;
            end
            csh_pkg::P_REQ_BR: begin
                fl_br.bridge = 1'b1;
                fl_er.bridge = 1'b1;
                bz_er        = 1'b1;
            end
            csh_pkg::P_PROP_ER: begin
                fl_br.er = 1'b1;
                fl_er.er = 1'b1;
                bz_er    = !acked;
            end
            csh_pkg::P_REQ_ER: begin
                fl_br.er = 1'b1;
                fl_er.er = 1'b1;
                bz_br    = 1'b1;
            end
            csh_pkg::P_LOC_EXIT: begin
                fl_er.er = 1'b1;
                bz_er    = !acked;
            end
            csh_pkg::P_LOC_ACK: begin
                fl_br.local_k = last_br;
                fl_er.local_k = !last_br;
                bz_br         = last_br;
                bz_er         = !last_br;
            end
            csh_pkg::P_FORCED: begin
                fl_br.er = 1'b1;
                bz_br    = 1'b1;
            end
            default: ;
        endcase
    end

    logic [7:0] next_setpoint;

    always_comb begin
        case (mode)
            csh_pkg::M_AUTO_BR:   next_setpoint = lev_br;
            csh_pkg::M_AUTO_ER:   next_setpoint = lev_er;
            csh_pkg::M_MANUAL_ER: next_setpoint = lev_man;
            default:              next_setpoint = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            br_led                  <= '0;
            er_led                  <= '0;
            br_buzzer               <= 1'b0;
            er_buzzer               <= 1'b0;
            mode_text               <= csh_pkg::T_LOCAL;
            bargraph_on             <= 1'b0;
            manual_engine_room_lamp <= 1'b0;
            local_lamp              <= 1'b0;
            emergency_lamp          <= 1'b0;
            remote_ind              <= 1'b0;
            setpoint                <= 8'h00;
        end else begin
            br_led      <= (steady & ~fl_br) | (fl_br & {3{blink}});
            er_led      <= (steady & ~fl_er) | (fl_er & {3{blink}});
            br_buzzer   <= bz_br;
            er_buzzer   <= bz_er;
            mode_text   <= csh_pkg::csh_text_t'(mode);
            bargraph_on <= pend inside {csh_pkg::P_LOC_EXIT, csh_pkg::P_PROP_BR,
                csh_pkg::P_REQ_BR, csh_pkg::P_PROP_ER, csh_pkg::P_REQ_ER};
            manual_engine_room_lamp <= (mode == csh_pkg::M_MANUAL_ER);
            local_lamp     <= (mode == csh_pkg::M_LOCAL);
            emergency_lamp <= (mode == csh_pkg::M_LOCAL);
            remote_ind     <= (mode != csh_pkg::M_LOCAL);
            setpoint       <= next_setpoint;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_local_wins;
        @(posedge clk) disable iff (!arst_n)
        !all_remote |=> mode == csh_pkg::M_LOCAL;
    endproperty
    a_local_wins: assert property (p_local_wins)
        else $error("local lever did not take control");

    property p_no_local_to_br;
        @(posedge clk) disable iff (!arst_n)
        (mode == csh_pkg::M_LOCAL ##1 mode == csh_pkg::M_AUTO_BR)
            |-> $past(pend) == csh_pkg::P_PROP_BR;
    endproperty
    a_no_local_to_br: assert property (p_no_local_to_br)
        else $error("local went to bridge without proposal");

    property p_aligned;
        @(posedge clk) disable iff (!arst_n)
        (mode != csh_pkg::M_AUTO_ER ##1 mode == csh_pkg::M_AUTO_ER
            && $past(mode) != csh_pkg::M_MANUAL_ER) |-> $past(lev_ok);
    endproperty
    a_aligned: assert property (p_aligned)
        else $error("transfer completed with levers apart");

    property p_cancel_br;
        @(posedge clk) disable iff (!arst_n)
        (pend == csh_pkg::P_PROP_BR && mode == csh_pkg::M_AUTO_ER
            && er_p.er && all_remote)
            |=> pend == csh_pkg::P_NONE && mode == csh_pkg::M_AUTO_ER;
    endproperty
    a_cancel_br: assert property (p_cancel_br)
        else $error("proposal to bridge not cancelled");

    property p_cancel_er;
        @(posedge clk) disable iff (!arst_n)
        (pend == csh_pkg::P_PROP_ER && br_p.bridge && sw_br && all_remote)
            |=> pend == csh_pkg::P_NONE && mode == csh_pkg::M_AUTO_BR;
    endproperty
    a_cancel_er: assert property (p_cancel_er)
        else $error("transfer to engine room not cancelled");

    property p_manual;
        @(posedge clk) disable iff (!arst_n)
        (mode == csh_pkg::M_AUTO_BR && all_remote && !sw_br
            && !(pend == csh_pkg::P_PROP_ER && acked))
            |=> mode == csh_pkg::M_MANUAL_ER ##1 manual_engine_room_lamp;
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual mode not entered at once");

    property p_quiet;
        @(posedge clk) disable iff (!arst_n)
        pend == csh_pkg::P_NONE |=> !br_buzzer && !er_buzzer;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("buzzer on with nothing pending");

    property p_steady_er;
        @(posedge clk) disable iff (!arst_n)
        (mode == csh_pkg::M_AUTO_ER && pend == csh_pkg::P_NONE)
            |=> br_led.er && er_led.er && mode_text == csh_pkg::T_AUTO_ER;
    endproperty
    a_steady_er: assert property (p_steady_er)
        else $error("auto engine room not shown steady");

    property p_req_to_prop;
        @(posedge clk) disable iff (!arst_n)
        (pend == csh_pkg::P_REQ_BR && er_p.bridge && all_remote
            && mode == csh_pkg::M_AUTO_ER)
            |=> pend == csh_pkg::P_PROP_BR && mode == csh_pkg::M_AUTO_ER;
    endproperty
    a_req_to_prop: assert property (p_req_to_prop)
        else $error("request ack did not become proposal");

    property p_setpoint;
        @(posedge clk) disable iff (!arst_n)
        mode == csh_pkg::M_MANUAL_ER |=> setpoint == $past(lev_man);
    endproperty
    a_setpoint: assert property (p_setpoint)
        else $error("manual set point not taken");

endmodule : csh_top

// [hw/csh_consts.svh]
/*
 * Offsets, field positions, reset values and timing counts for the
 * control station handover block. Included by bare name.
 */
`ifndef CSH_CONSTS_SVH
`define CSH_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CSH_OFF_CTRL      8'h00
`define CSH_OFF_STATUS    8'h04
`define CSH_OFF_LEVERS    8'h08
`define CSH_OFF_SETPOINT  8'h0C

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CSH_CTRL_TOL_LSB  0
`define CSH_ST_MODE_LSB   0
`define CSH_ST_PEND_LSB   2
`define CSH_ST_ACK_BIT    5
`define CSH_LEV_ER_LSB    8
`define CSH_TOL_RST       8'h04

// ----------------------------------------
// timing
// ----------------------------------------
`define CSH_CLK_KHZ       50000
`define CSH_FLASH_HALF_MS 500
`define CSH_FLASH_HALF_CYC (`CSH_FLASH_HALF_MS * `CSH_CLK_KHZ)

`endif

// [hw/csh_pkg.sv]
/*
 * Types for the control station handover block.
 * Assumes csh_consts.svh carries every number.
 */
package csh_pkg;

    typedef enum logic [1:0] {
        M_LOCAL, M_AUTO_ER, M_AUTO_BR, M_MANUAL_ER
    } csh_mode_t;

    typedef enum logic [2:0] {
        P_NONE, P_LOC_ACK, P_LOC_EXIT, P_PROP_BR,
        P_REQ_BR, P_PROP_ER, P_REQ_ER, P_FORCED
    } csh_pend_t;

    // one panel: bridge-control, engine_room_station_key, local-control
    typedef struct packed {
        logic bridge;
        logic er;
        logic local_k;
    } csh_keys_t;

    typedef enum logic [1:0] {
        T_LOCAL, T_AUTO_ER, T_AUTO_BR, T_MANUAL_ER
    } csh_text_t;

endpackage : csh_pkg

// [testbench/csh_panels.sv]
/*
 * Operator panels, changeover switch and local lever contacts.
 * Assumes the caller runs its tasks from the bench's clock domain.
 */
`timescale 1ns/100ps
module csh_panels (
    // clock
    input  wire logic          clk,
    // contacts
    output csh_pkg::csh_keys_t br_keys,
    output csh_pkg::csh_keys_t er_keys,
    output logic               sw_at_bridge,
    output logic [1:0]         lever_remote
);
    initial begin
        br_keys = '0;
        er_keys = '0;
        sw_at_bridge = 1'b1;
        lever_remote = 2'b00;
    end
    // held six cycles so the two sync flops cannot miss it
    task automatic press(input logic at_br, input csh_pkg::csh_keys_t k);
        @(posedge clk);
        if (at_br) br_keys <= k;
        else er_keys <= k;
        repeat (6) @(posedge clk);
        br_keys <= '0;
        er_keys <= '0;
        repeat (12) @(posedge clk);
    endtask : press
    task automatic set_pos(input logic sw, input logic [1:0] lev);
        @(posedge clk);
        sw_at_bridge <= sw;
        lever_remote <= lev;
        repeat (10) @(posedge clk);
    endtask : set_pos
endmodule : csh_panels

// [testbench/test_control_station_handover.sv]
/*
 * Self-checking bench for the handover block.
 * Assumes zero wait-state bus answers and FLASH_CYC shortened to 4.
 */
`timescale 1ns/100ps
module test_control_station_handover;
    logic clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, st;
    logic hready, br_buzzer, er_buzzer, lamp_m, lamp_l, lamp_e, remote_ind;
    logic [1:0] lev;
    logic [7:0] setpoint;
    logic sw;
    logic bar, resp, pot = 1'b0;
    csh_pkg::csh_keys_t br_keys, er_keys, br_led, er_led;
    csh_pkg::csh_text_t mode_text;
    int err_count = 0, comparisons = 0;
    localparam csh_pkg::csh_keys_t BK = 3'h4, EK = 3'h2;
    always #10 clk = ~clk;
    csh_panels csh_panels_inst (.clk(clk), .br_keys(br_keys), .er_keys(er_keys),
        .sw_at_bridge(sw), .lever_remote(lev));
    csh_top #(.FLASH_CYC(4)) csh_top_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(resp), .br_keys(br_keys),
        .er_keys(er_keys), .sw_at_bridge(sw), .lever_remote(lev), .er_pot_fault(pot),
        .br_lever(8'h10), .er_lever(8'h10), .man_lever(8'h33), .br_led(br_led),
        .er_led(er_led), .br_buzzer(br_buzzer), .er_buzzer(er_buzzer),
        .mode_text(mode_text), .bargraph_on(bar), .manual_engine_room_lamp(lamp_m),
        .local_lamp(lamp_l), .emergency_lamp(lamp_e), .remote_ind(remote_ind),
        .setpoint(setpoint));
    task automatic tally_and_finish;
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // single word read, held until hready is seen at each edge
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 50);
        htrans <= 2'h0;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 50);
        st = hrdata & 32'h1F;
        hsel <= 1'b0;
        if (n >= 50) begin
            err_count++;
            tally_and_finish();
        end
    endtask : rd
    // single word write: address phase, then hwdata held through the data phase
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 50);
        hsel <= 1'b0;
        hwrite <= 1'b0;
        if (n >= 50) begin
            err_count++;
            tally_and_finish();
        end
    endtask : wr
    task automatic wait_text(input csh_pkg::csh_text_t t);
        int i;
        for (i = 0; i < 40 && mode_text !== t; i++) @(posedge clk);
        if (i >= 40) begin
            err_count++;
            tally_and_finish();
        end
        repeat (2) @(posedge clk);
        chk(mode_text, t);
    endtask : wait_text
    task automatic s_reset;
        rd(8'h00);
        chk(st, 32'h04);
        rd(8'h10);
        chk(st, 32'h0);
        chk(resp, 1'b0);
        wr(8'h00, 32'h07);
        rd(8'h00);
        chk(st, 32'h07);
    endtask : s_reset
    task automatic s_to_remote;
        csh_panels_inst.set_pos(1'b1, 2'b11);
        rd(8'h04);
        chk(st, 32'h08);
        chk(er_buzzer, 1'b1);
        csh_panels_inst.press(1'b0, EK);
        wait_text(csh_pkg::T_AUTO_ER);
        chk({remote_ind, er_led, br_led, er_buzzer}, 8'hA4);
    endtask : s_to_remote
    task automatic s_bridge;
        csh_panels_inst.press(1'b0, BK);
        rd(8'h04);
        chk(st, 32'h0D);
        chk(br_buzzer, 1'b1);
        csh_panels_inst.press(1'b0, EK);
        rd(8'h04);
        chk(st, 32'h01);
        csh_panels_inst.press(1'b1, BK);
        rd(8'h04);
        chk(st, 32'h11);
        chk(er_buzzer, 1'b1);
        csh_panels_inst.press(1'b0, BK);
        rd(8'h04);
        chk(st, 32'h0D);
        csh_panels_inst.press(1'b1, BK);
        wait_text(csh_pkg::T_AUTO_BR);
        chk(br_buzzer, 1'b0);
    endtask : s_bridge
    task automatic s_pot;
        @(posedge clk);
        pot <= 1'b1;
        csh_panels_inst.set_pos(1'b1, 2'b11);
        rd(8'h04);
        chk(st, 32'h0C);
        chk({bar, br_buzzer}, 2'b11);
        csh_panels_inst.press(1'b1, BK);
        wait_text(csh_pkg::T_AUTO_BR);
        chk({bar, br_buzzer}, 2'b00);
    endtask : s_pot
    task automatic s_manual_local;
        csh_panels_inst.set_pos(1'b0, 2'b11);
        wait_text(csh_pkg::T_MANUAL_ER);
        chk({lamp_m, setpoint}, 9'h133);
        csh_panels_inst.set_pos(1'b0, 2'b01);
        wait_text(csh_pkg::T_LOCAL);
        chk({lamp_l, lamp_e}, 2'b11);
    endtask : s_manual_local
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        s_reset();
        s_to_remote();
        s_bridge();
        s_manual_local();
        s_pot();
        tally_and_finish();
    end
endmodule : test_control_station_handover
